/* mcm_params.svh */
// constants for the mac configuration access block
`ifndef MCM_PARAMS_SVH
`define MCM_PARAMS_SVH
// vector widths
`define MCM_TX_W          368
`define MCM_RX_W          96
`define MCM_BASE_W        80
`define MCM_PRIO_N        8
`define MCM_TX_REG_W      384
// management bus word map (word index = byte address / 4)
`define MCM_TX_WORDS      9'h00C
`define MCM_RX_WORD0      9'h010
`define MCM_RX_WORDS      9'h003
`define MCM_STAT_WORD     9'h018
`define MCM_RESP_OKAY     2'h0
`define MCM_RESP_SLVERR   2'h2
// bits of the base vectors that act at once (reset and flow control)
`define MCM_TX_IMM_MASK   80'hFF00_0000_0000_0000_0061
`define MCM_RX_IMM_MASK   80'h0000_0000_0000_0000_0021
// transmit field positions
`define MCM_TX_FC_BIT     5
`define MCM_TX_RESUME_BIT 6
`define MCM_PFC_EN_LSB    72
`define MCM_PFC_LSB       96
`define MCM_PFC_STRIDE    32
`define MCM_REFRESH_OFS   16
`define MCM_LEG_REF_LSB   352
// one pause quantum (512 bit times at 10 Gb/s) and the clock period
`define MCM_QUANTA_PS     51200
`define MCM_CLK_PS        50000
`define MCM_QUANTA_CYC    ((`MCM_QUANTA_PS / `MCM_CLK_PS) < 1 ? 1 : (`MCM_QUANTA_PS / `MCM_CLK_PS))
`endif

/* mcm_pkg.sv */
// types shared by the mac configuration access block
`include "mcm_params.svh"
package mcm_pkg;
	// complete state of the block
	typedef struct packed {
		logic [`MCM_TX_REG_W-1:0]          tx_reg;      // bus-written transmit words
		logic [`MCM_RX_W-1:0]              rx_reg;      // bus-written receive words
		logic [`MCM_TX_W-1:0]              tx_app;      // applied transmit vector
		logic [`MCM_RX_W-1:0]              rx_app;      // applied receive vector
		logic [1:0]                        sync1;       // status pin stage 1
		logic [1:0]                        sync2;       // status pin stage 2
		logic [1:0]                        sync3;       // status pin stage 3
		logic [1:0]                        status;      // filtered status
		logic                              awready;     // write address ready
		logic                              wready;      // write data ready
		logic                              bvalid;      // write response valid
		logic [1:0]                        bresp;       // write response code
		logic                              arready;     // read address ready
		logic                              rvalid;      // read data valid
		logic [1:0]                        rresp;       // read response code
		logic [31:0]                       rdata;       // read data
		logic [7:0]                        qdiv;        // quanta tick divider
		logic                              pause_req_d; // last legacy request
		logic [15:0]                       pause_cnt;   // legacy quanta count
		logic                              pause_send;  // pause frame strobe
		logic                              resume_send; // resume frame strobe
		logic [`MCM_PRIO_N-1:0]            pfc_req_d;   // last priority requests
		logic [`MCM_PRIO_N-1:0]            pfc_send;    // priority frame strobes
		logic [`MCM_PRIO_N-1:0][15:0]      pfc_cnt;     // priority quanta counts
		logic [`MCM_PRIO_N-1:0][15:0]      pfc_quanta;  // quanta put into frames
	} mcm_state_s;
endpackage

/* mcm_cfg_mgmt.sv */
// configuration access layer of a 10g ethernet mac
//
// Functional notes
// - optional 32-bit management slave reaches configuration
// - without bus, configuration vectors are used
// - 80-bit tx/rx vectors, 2-bit status output
// - priority build widens vectors to 368/96 bits
// - changes apply after frame; reset/flow immediate
// - priority build gives level-held on/off pause
// - held request: pause, then refresh at value
// - release with auto resume sends resume frame
// - each priority refreshes at own 16-bit value
// - enabled priority inserts its own quanta value
`timescale 1ns/1ns
`include "mcm_params.svh"

module mcm_cfg_mgmt
	import mcm_pkg::*;
#(
	parameter bit MGMT_EN = 1'h0, // build with the management bus
	parameter bit PFC_EN  = 1'h1  // build with priority flow control
) (
	input  wire logic                   SYS_CLK,
	input  wire logic                   RESET_N,
	input  wire logic [10:0]            S_AXI_AWADDR,
	input  wire logic                   S_AXI_AWVALID,
	output wire logic                   S_AXI_AWREADY,
	input  wire logic [31:0]            S_AXI_WDATA,
	input  wire logic                   S_AXI_WVALID,
	output wire logic                   S_AXI_WREADY,
	output wire logic [1:0]             S_AXI_BRESP,
	output wire logic                   S_AXI_BVALID,
	input  wire logic                   S_AXI_BREADY,
	input  wire logic [10:0]            S_AXI_ARADDR,
	input  wire logic                   S_AXI_ARVALID,
	output wire logic                   S_AXI_ARREADY,
	output wire logic [31:0]            S_AXI_RDATA,
	output wire logic [1:0]             S_AXI_RRESP,
	output wire logic                   S_AXI_RVALID,
	input  wire logic                   S_AXI_RREADY,
	input  wire logic [`MCM_TX_W-1:0]   TX_CFG_IN,
	input  wire logic [`MCM_RX_W-1:0]   RX_CFG_IN,
	input  wire logic                   TX_FRAME_BUSY,
	input  wire logic                   RX_FRAME_BUSY,
	input  wire logic [1:0]             STATUS_IN,
	input  wire logic                   PAUSE_REQ,
	input  wire logic [`MCM_PRIO_N-1:0] PFC_REQ,
	output wire logic [`MCM_TX_W-1:0]   TX_CFG_OUT,
	output wire logic [`MCM_RX_W-1:0]   RX_CFG_OUT,
	output wire logic [1:0]             MAC_STATUS,
	output wire logic                   PAUSE_SEND,
	output wire logic                   RESUME_SEND,
	output wire logic [`MCM_PRIO_N-1:0] PFC_SEND,
	output wire logic [127:0]           PFC_QUANTA
);

	////////////////////////////////////////////////////////////////////////////////
	// declarations

	mcm_state_s                   r;           // registered state
	mcm_state_s                   n;           // next state
	logic [`MCM_TX_W-1:0]         tx_src;      // selected transmit source
	logic [`MCM_RX_W-1:0]         rx_src;      // selected receive source
	logic [`MCM_TX_W-1:0]         tx_imm;      // transmit bits that act at once
	logic [`MCM_RX_W-1:0]         rx_imm;      // receive bits that act at once
	logic [`MCM_TX_W-1:0]         tx_keep;     // transmit bits present in this build
	logic [`MCM_RX_W-1:0]         rx_keep;     // receive bits present in this build
	logic [8:0]                   wword;       // write word index
	logic [8:0]                   rword;       // read word index
	logic                         wr_go;       // write accepted this cycle
	logic                         rd_go;       // read accepted this cycle
	logic                         tick;        // one pause quantum elapsed
	logic                         leg_req;     // legacy request, flow control on
	logic [`MCM_PRIO_N-1:0]       pfc_req;     // enabled priority requests
	logic [`MCM_PRIO_N-1:0]       pfc_fire;    // priority frame due
	logic [`MCM_PRIO_N-1:0][15:0] pfc_cnt_nxt; // next priority counts
	logic [`MCM_PRIO_N-1:0][15:0] pfc_q_nxt;   // next inserted quanta

	////////////////////////////////////////////////////////////////////////////////
	// source selection and masks

	// bus registers replace the vector inputs when the bus is built
	assign tx_src  = MGMT_EN ? r.tx_reg[`MCM_TX_W-1:0] : TX_CFG_IN;
	assign rx_src  = MGMT_EN ? r.rx_reg : RX_CFG_IN;
	// every priority field is flow control, so it acts at once
	assign tx_imm  = {{(`MCM_TX_W-`MCM_BASE_W){1'h1}}, `MCM_TX_IMM_MASK};
	assign rx_imm  = {{(`MCM_RX_W-`MCM_BASE_W){1'h1}}, `MCM_RX_IMM_MASK};
	// upper bits only exist in the priority build
	assign tx_keep = {{(`MCM_TX_W-`MCM_BASE_W){PFC_EN}}, {`MCM_BASE_W{1'h1}}};
	assign rx_keep = {{(`MCM_RX_W-`MCM_BASE_W){PFC_EN}}, {`MCM_BASE_W{1'h1}}};
	assign wword   = S_AXI_AWADDR[10:2];
	assign rword   = S_AXI_ARADDR[10:2];
	assign wr_go   = r.awready & S_AXI_AWVALID & S_AXI_WVALID;
	assign rd_go   = r.arready & S_AXI_ARVALID;
	assign tick    = (r.qdiv == 8'(`MCM_QUANTA_CYC - 1));
	assign leg_req = PAUSE_REQ & r.tx_app[`MCM_TX_FC_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// per-priority pause logic

	// each priority owns a quanta word and the refresh word just above it
	for (genvar p = 0; p < `MCM_PRIO_N; p++) begin : g_prio
		localparam int QL = `MCM_PFC_LSB + p * `MCM_PFC_STRIDE;
		localparam int RL = QL + `MCM_REFRESH_OFS;
		// request counts only when that priority is enabled
		assign pfc_req[p]     = PFC_EN & PFC_REQ[p] & r.tx_app[`MCM_PFC_EN_LSB + p];
		// first frame on assertion, then one each time the count meets refresh
		assign pfc_fire[p]    = pfc_req[p] &
			(!r.pfc_req_d[p] | (tick & (r.pfc_cnt[p] == r.tx_app[RL +: 16])));
		assign pfc_cnt_nxt[p] = (!pfc_req[p] || pfc_fire[p]) ? 16'h0000 :
			(tick ? r.pfc_cnt[p] + 16'h0001 : r.pfc_cnt[p]);
		// quanta of an enabled and asserted priority go into the frame
		assign pfc_q_nxt[p]   = pfc_req[p] ? r.tx_app[QL +: 16] : 16'h0000;
		// a new priority request sends a frame next cycle
		pfc_first_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
			$rose(pfc_req[p]) |=> PFC_SEND[p])
			else $error("no priority frame on request");
		// held priority refreshes when its count meets the refresh value
		pfc_refresh_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
			pfc_req[p] && r.pfc_req_d[p] && tick && r.pfc_cnt[p] == r.tx_app[RL +: 16]
			|=> PFC_SEND[p])
			else $error("priority refresh missed");
		// enabled and asserted priority carries its quanta, any other carries zero
		pfc_quanta_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
			1'h1 |=> PFC_QUANTA[16 * p +: 16] ==
			($past(pfc_req[p]) ? $past(r.tx_app[QL +: 16]) : 16'h0000))
			else $error("priority quanta wrong");
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state

	// all state changes are computed here
	always_comb begin
		n = r;
		// status pins: three stages, change taken once stages two and three agree
		n.sync1 = STATUS_IN;
		n.sync2 = r.sync1;
		n.sync3 = r.sync2;
		if (r.sync2 == r.sync3) begin
			n.status = r.sync3;
		end
		// deferred bits wait for the frame to end, immediate bits pass now
		if (TX_FRAME_BUSY) begin
			n.tx_app = ((r.tx_app & ~tx_imm) | (tx_src & tx_imm)) & tx_keep;
		end else begin
			n.tx_app = tx_src & tx_keep;
		end
		if (RX_FRAME_BUSY) begin
			n.rx_app = ((r.rx_app & ~rx_imm) | (rx_src & rx_imm)) & rx_keep;
		end else begin
			n.rx_app = rx_src & rx_keep;
		end
		// write channel: address and data taken together, one at a time
		n.awready = 1'h0;
		n.wready  = 1'h0;
		if (MGMT_EN && S_AXI_AWVALID && S_AXI_WVALID && !r.awready && !r.bvalid) begin
			n.awready = 1'h1;
			n.wready  = 1'h1;
		end
		if (wr_go) begin
			n.bvalid = 1'h1;
			n.bresp  = `MCM_RESP_OKAY;
			if (wword < `MCM_TX_WORDS) begin
				n.tx_reg[{wword[3:0], 5'h00} +: 32] = S_AXI_WDATA;
			end else if (wword >= `MCM_RX_WORD0 && wword < `MCM_RX_WORD0 + `MCM_RX_WORDS) begin
				n.rx_reg[{wword[1:0], 5'h00} +: 32] = S_AXI_WDATA;
			end else begin
				n.bresp = `MCM_RESP_SLVERR; // unmapped or read-only word
			end
		end else if (r.bvalid && S_AXI_BREADY) begin
			n.bvalid = 1'h0;
		end
		// read channel: one outstanding read
		n.arready = 1'h0;
		if (MGMT_EN && S_AXI_ARVALID && !r.arready && !r.rvalid) begin
			n.arready = 1'h1;
		end
		if (rd_go) begin
			n.rvalid = 1'h1;
			n.rresp  = `MCM_RESP_OKAY;
			n.rdata  = 32'h0000_0000;
			if (rword < `MCM_TX_WORDS) begin
				n.rdata = r.tx_reg[{rword[3:0], 5'h00} +: 32];
			end else if (rword >= `MCM_RX_WORD0 && rword < `MCM_RX_WORD0 + `MCM_RX_WORDS) begin
				n.rdata = r.rx_reg[{rword[1:0], 5'h00} +: 32];
			end else if (rword == `MCM_STAT_WORD) begin
				n.rdata = {30'h0000_0000, r.status}; // live status
			end else begin
				n.rresp = `MCM_RESP_SLVERR; // unmapped word
			end
		end else if (r.rvalid && S_AXI_RREADY) begin
			n.rvalid = 1'h0;
		end
		// quanta divider
		n.qdiv = tick ? 8'h00 : r.qdiv + 8'h01;
		// legacy pause as an on/off interface
		n.pause_req_d = leg_req;
		n.pause_send  = 1'h0;
		n.resume_send = 1'h0;
		if (leg_req && !r.pause_req_d) begin
			n.pause_send = 1'h1;
			n.pause_cnt  = 16'h0000;
		end else if (leg_req && PFC_EN && tick) begin
			// refresh only exists in the priority build
			if (r.pause_cnt == r.tx_app[`MCM_LEG_REF_LSB +: 16]) begin
				n.pause_send = 1'h1;
				n.pause_cnt  = 16'h0000;
			end else begin
				n.pause_cnt = r.pause_cnt + 16'h0001;
			end
		end else if (!leg_req) begin
			n.pause_cnt = 16'h0000;
			// release with auto resume sends a resume frame unprompted
			if (r.pause_req_d && PFC_EN && r.tx_app[`MCM_TX_RESUME_BIT]) begin
				n.resume_send = 1'h1;
			end
		end
		// priority pause strobes and counts
		n.pfc_req_d  = pfc_req;
		n.pfc_send   = pfc_fire;
		n.pfc_cnt    = pfc_cnt_nxt;
		n.pfc_quanta = pfc_q_nxt;
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	// whole state clears on reset
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, all straight from the state register

	assign S_AXI_AWREADY = r.awready;
	assign S_AXI_WREADY  = r.wready;
	assign S_AXI_BRESP   = r.bresp;
	assign S_AXI_BVALID  = r.bvalid;
	assign S_AXI_ARREADY = r.arready;
	assign S_AXI_RDATA   = r.rdata;
	assign S_AXI_RRESP   = r.rresp;
	assign S_AXI_RVALID  = r.rvalid;
	assign TX_CFG_OUT    = r.tx_app;
	assign RX_CFG_OUT    = r.rx_app;
	assign MAC_STATUS    = r.status;
	assign PAUSE_SEND    = r.pause_send;
	assign RESUME_SEND   = r.resume_send;
	assign PFC_SEND      = r.pfc_send;
	assign PFC_QUANTA    = r.pfc_quanta;

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RESET_N);

	// accepted write answers with a response next cycle
	wr_resp_a: assert property (wr_go |=> S_AXI_BVALID && !S_AXI_AWREADY)
		else $error("write not answered");
	// accepted read answers with data next cycle
	rd_resp_a: assert property (rd_go |=> S_AXI_RVALID && !S_AXI_ARREADY)
		else $error("read not answered");
	// response stands until taken
	resp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write response dropped");
	// a deferred bit holds while a frame is sent
	tx_defer_a: assert property (TX_FRAME_BUSY |=> $stable(TX_CFG_OUT[4:1]))
		else $error("transmit setting changed mid frame");
	// flow control bit follows the source at once
	fc_now_a: assert property (1'h1 |=> TX_CFG_OUT[`MCM_TX_FC_BIT] == $past(tx_src[`MCM_TX_FC_BIT]))
		else $error("flow control bit delayed");
	// upper bits follow the source at once in the priority build, else read zero
	width_gate_a: assert property (1'h1 |=> TX_CFG_OUT[`MCM_TX_W-1:`MCM_BASE_W] ==
		($past(tx_src[`MCM_TX_W-1:`MCM_BASE_W]) & {(`MCM_TX_W-`MCM_BASE_W){PFC_EN}}))
		else $error("priority bits wrong for this build");
	// new legacy request sends a pause frame next cycle
	pause_first_a: assert property ($rose(leg_req) |=> PAUSE_SEND)
		else $error("no pause frame on request");
	// held legacy request refreshes when its count meets the refresh value
	pause_refresh_a: assert property (leg_req && r.pause_req_d && PFC_EN && tick &&
		r.pause_cnt == r.tx_app[`MCM_LEG_REF_LSB +: 16] |=> PAUSE_SEND)
		else $error("legacy pause refresh missed");
	// release with auto resume gives a resume frame
	resume_send_a: assert property ($fell(leg_req) && PFC_EN &&
		r.tx_app[`MCM_TX_RESUME_BIT] |=> RESUME_SEND)
		else $error("no resume frame on release");
	// status follows the agreed synchroniser stages
	status_sync_a: assert property (r.sync2 == r.sync3 |=> MAC_STATUS == $past(r.sync3))
		else $error("status not updated");

	wr_seen_c:     cover property (wr_go ##1 S_AXI_BVALID && S_AXI_BREADY);
	pause_seen_c:  cover property (PAUSE_SEND ##[1:40] PAUSE_SEND);
	resume_seen_c: cover property (RESUME_SEND);
	pfc_seen_c:    cover property (PFC_SEND[7]);

endmodule

/* mcm_tx_model.sv */
// transmit side model that counts the pause, resume and priority 3 and 4 frames it is asked to send
`timescale 1ns/1ns

module mcm_tx_model (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       pause_send,
	input  wire logic       resume_send,
	input  wire logic [7:0] pfc_send,
	output logic      [7:0] pause_cnt,
	output logic      [7:0] resume_cnt,
	output logic      [7:0] pfc3_cnt,
	output logic      [7:0] pfc4_cnt
);
	//////////////////////////////////////////////////////////////////////////
	// one frame is queued for every pause, resume, priority 3 or priority 4 strobe seen at a rising edge
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			// nothing queued after reset
			pause_cnt  <= 8'h00;
			resume_cnt <= 8'h00;
			pfc3_cnt   <= 8'h00;
			pfc4_cnt   <= 8'h00;
		end else begin
			// a strobe lasts one cycle, so each edge counts at most one frame
			pause_cnt  <= pause_cnt + {7'h00, pause_send};
			resume_cnt <= resume_cnt + {7'h00, resume_send};
			pfc3_cnt   <= pfc3_cnt + {7'h00, pfc_send[3]};
			pfc4_cnt   <= pfc4_cnt + {7'h00, pfc_send[4]};
		end
	end
endmodule

/* tb_top.sv */
// self-checking bench for the mac configuration access block in vector and bus modes
`timescale 1ns/1ns
`include "mcm_params.svh"

`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); end end

module tb_top;
	import mcm_pkg::*;
	// one row of the plain configuration cases
	typedef struct packed {
		logic [`MCM_TX_W-1:0] tx;
		logic [`MCM_RX_W-1:0] rx;
		logic                 tb;
		logic                 rb;
	} mcm_row_s;
	logic                   sys_clk, reset_n;                // clock and reset
	logic [10:0]            awaddr, araddr;                  // idle bus addresses
	logic [31:0]            wdata;                           // idle bus data
	logic                   awvalid, wvalid, bready, arvalid, rready;
	wire logic              awready, wready, bvalid, arready, rvalid;
	wire logic [1:0]        bresp, rresp, mac_status;
	wire logic [31:0]       rdata;
	logic [`MCM_TX_W-1:0]   tx_cfg, exp_tx, tx_imm;          // vector in, model, fast bits
	logic [`MCM_RX_W-1:0]   rx_cfg, exp_rx, rx_imm;
	wire logic [`MCM_TX_W-1:0] tx_out;
	wire logic [`MCM_RX_W-1:0] rx_out;
	logic                   tx_busy, rx_busy, pause_req;     // frame and request pins
	logic [1:0]             status_in;                       // asynchronous status pins
	logic [7:0]             pfc_req;                         // priority requests
	wire logic              pause_send, resume_send;
	wire logic [7:0]        pfc_send;
	wire logic [127:0]      pfc_quanta;
	wire logic              awready_b, wready_b, bvalid_b, arready_b, rvalid_b; // bus build
	wire logic [1:0]        bresp_b, rresp_b;
	wire logic [31:0]       rdata_b;
	wire logic [`MCM_TX_W-1:0] tx_out_b;
	wire logic [`MCM_RX_W-1:0] rx_out_b;
	wire logic [7:0]        pause_cnt, resume_cnt, pfc3_cnt, pfc4_cnt;
	logic [7:0]             p0, r0, q3, q4;                  // counts before a scenario
	int                     errors, check_count;
	mcm_row_s               rows [4];

	mcm_cfg_mgmt #(.MGMT_EN(1'h0), .PFC_EN(1'h1)) mcm_cfg_mgmt_inst (
		.SYS_CLK(sys_clk), .RESET_N(reset_n), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
		.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.TX_CFG_IN(tx_cfg), .RX_CFG_IN(rx_cfg), .TX_FRAME_BUSY(tx_busy),
		.RX_FRAME_BUSY(rx_busy), .STATUS_IN(status_in), .PAUSE_REQ(pause_req),
		.PFC_REQ(pfc_req), .TX_CFG_OUT(tx_out), .RX_CFG_OUT(rx_out),
		.MAC_STATUS(mac_status), .PAUSE_SEND(pause_send), .RESUME_SEND(resume_send),
		.PFC_SEND(pfc_send), .PFC_QUANTA(pfc_quanta));

	mcm_tx_model mcm_tx_model_inst (
		.clk(sys_clk), .reset_n(reset_n), .pause_send(pause_send),
		.resume_send(resume_send), .pfc_send(pfc_send), .pause_cnt(pause_cnt),
		.resume_cnt(resume_cnt), .pfc3_cnt(pfc3_cnt), .pfc4_cnt(pfc4_cnt));

	// a second build with the management bus, sharing every input
	if (1'h1) begin : g_bus
		mcm_cfg_mgmt #(.MGMT_EN(1'h1), .PFC_EN(1'h1)) mcm_cfg_mgmt_inst (
			.SYS_CLK(sys_clk), .RESET_N(reset_n), .S_AXI_AWADDR(awaddr),
			.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready_b), .S_AXI_WDATA(wdata),
			.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready_b), .S_AXI_BRESP(bresp_b),
			.S_AXI_BVALID(bvalid_b), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
			.S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready_b), .S_AXI_RDATA(rdata_b),
			.S_AXI_RRESP(rresp_b), .S_AXI_RVALID(rvalid_b), .S_AXI_RREADY(rready),
			.TX_CFG_IN(tx_cfg), .RX_CFG_IN(rx_cfg), .TX_FRAME_BUSY(tx_busy),
			.RX_FRAME_BUSY(rx_busy), .STATUS_IN(status_in), .PAUSE_REQ(pause_req),
			.PFC_REQ(pfc_req), .TX_CFG_OUT(tx_out_b), .RX_CFG_OUT(rx_out_b),
			.MAC_STATUS(), .PAUSE_SEND(), .RESUME_SEND(),
			.PFC_SEND(), .PFC_QUANTA());
	end

	//////////////////////////////////////////////////////////////////////////
	// 20 mhz clock, inside the management clock range
	initial begin
		sys_clk = 1'h0;
		forever #25 sys_clk = ~sys_clk;
	end

	// verdict and end of run
	task automatic results();
		if (errors == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// one write on the bus build, response held back a cycle by bready
	task automatic bus_write(input logic [10:0] a, input logic [31:0] d, input logic [1:0] rsp);
		int n;
		awaddr = a;
		wdata = d;
		awvalid = 1'h1;
		wvalid = 1'h1;
		for (n = 0; n < 8 && awready_b !== 1'h1; n++) @(negedge sys_clk);
		if (n == 8) begin
			errors++;
			results();
		end
		`CHK(wready_b, 1'h1)
		// the next rising edge takes address and data
		@(negedge sys_clk);
		awvalid = 1'h0;
		wvalid = 1'h0;
		bready = 1'h0;
		@(negedge sys_clk);
		bready = 1'h1;
		`CHK({bvalid_b, bresp_b}, {1'h1, rsp})
		@(negedge sys_clk);
	endtask

	// one read on the bus build, data taken while it stands
	task automatic bus_read(input logic [10:0] a, input logic [31:0] d, input logic [1:0] rsp);
		int n;
		araddr = a;
		arvalid = 1'h1;
		for (n = 0; n < 8 && arready_b !== 1'h1; n++) @(negedge sys_clk);
		if (n == 8) begin
			errors++;
			results();
		end
		@(negedge sys_clk);
		arvalid = 1'h0;
		`CHK({rvalid_b, rresp_b, rdata_b}, {1'h1, rsp, d})
		@(negedge sys_clk);
	endtask

	// cuts a hang short
	initial begin
		repeat (100000) @(posedge sys_clk);
		errors++;
		results();
	end

	//////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		errors = 0; check_count = 0; reset_n = 1'h0;
		// bus requests held up until the bus build checks: vector build must ignore them
		awaddr = 11'h000; araddr = 11'h040; wdata = 32'hDEAD_BEEF;
		awvalid = 1'h1; wvalid = 1'h1; arvalid = 1'h1; bready = 1'h1; rready = 1'h1;
		tx_cfg = '0; rx_cfg = '0; tx_busy = 1'h0; rx_busy = 1'h0;
		pause_req = 1'h0; pfc_req = 8'h00; status_in = 2'h0;
		tx_imm = {{288{1'h1}}, `MCM_TX_IMM_MASK};
		rx_imm = {{16{1'h1}}, `MCM_RX_IMM_MASK};
		rows[0] = '{{46{8'h5A}}, {12{8'h3C}}, 1'h0, 1'h0};
		rows[1] = '{{46{8'hA5}}, {12{8'hC3}}, 1'h1, 1'h1};
		rows[2] = '{{46{8'hA5}}, {12{8'hC3}}, 1'h0, 1'h0};
		rows[3] = '{{46{8'h00}}, {12{8'hFF}}, 1'h1, 1'h0};
		repeat (4) @(negedge sys_clk);
		`CHK(tx_out, {`MCM_TX_W{1'h0}})
		`CHK({pause_send, resume_send, pfc_send}, 10'h000)
		reset_n = 1'h1;
		exp_tx = '0; exp_rx = '0;
		// plain cases: busy holds back all but the fast bits
		foreach (rows[i]) begin
			@(negedge sys_clk);
			tx_cfg = rows[i].tx; rx_cfg = rows[i].rx;
			tx_busy = rows[i].tb; rx_busy = rows[i].rb;
			exp_tx = rows[i].tb ? (exp_tx & ~tx_imm) | (rows[i].tx & tx_imm) : rows[i].tx;
			exp_rx = rows[i].rb ? (exp_rx & ~rx_imm) | (rows[i].rx & rx_imm) : rows[i].rx;
			@(negedge sys_clk);
			`CHK(tx_out, exp_tx)
			`CHK(rx_out, exp_rx)
		end
		tx_busy = 1'h0; rx_busy = 1'h0;
		// status pins reach the status vector through the synchroniser
		status_in = 2'h2;
		repeat (6) @(negedge sys_clk);
		`CHK(mac_status, 2'h2)
		// held legacy request with refresh 2, with and without auto resume
		for (int a = 0; a < 2; a++) begin
			tx_cfg = '0; tx_cfg[`MCM_TX_FC_BIT] = 1'h1;
			tx_cfg[`MCM_TX_RESUME_BIT] = a[0];
			tx_cfg[`MCM_LEG_REF_LSB +: 16] = 16'h0002;
			repeat (2) @(negedge sys_clk);
			p0 = pause_cnt; r0 = resume_cnt;
			pause_req = 1'h1;
			repeat (8) @(negedge sys_clk);
			pause_req = 1'h0;
			repeat (3) @(negedge sys_clk);
			`CHK(pause_cnt - p0, 8'h03)
			`CHK(resume_cnt - r0, {7'h00, a[0]})
		end
		// priority 3 enabled, priority 4 requested but disabled
		tx_cfg = '0; tx_cfg[`MCM_PFC_EN_LSB + 3] = 1'h1;
		tx_cfg[`MCM_PFC_LSB + 3 * `MCM_PFC_STRIDE +: 16] = 16'h1234;
		tx_cfg[`MCM_PFC_LSB + 3 * `MCM_PFC_STRIDE + `MCM_REFRESH_OFS +: 16] = 16'h0001;
		tx_cfg[`MCM_PFC_LSB + 4 * `MCM_PFC_STRIDE +: 16] = 16'h5678;
		tx_cfg[`MCM_PFC_LSB + 4 * `MCM_PFC_STRIDE + `MCM_REFRESH_OFS +: 16] = 16'h0001;
		repeat (2) @(negedge sys_clk);
		q3 = pfc3_cnt; q4 = pfc4_cnt;
		pfc_req = 8'h18;
		repeat (2) @(negedge sys_clk);
		`CHK(pfc_quanta[63:48], 16'h1234)
		`CHK(pfc_quanta[79:64], 16'h0000)
		repeat (5) @(negedge sys_clk);
		pfc_req = 8'h00;
		repeat (3) @(negedge sys_clk);
		`CHK(pfc3_cnt - q3, 8'h04)
		`CHK(pfc4_cnt - q4, 8'h00)
		`CHK(pfc_quanta[63:48], 16'h0000)
		// the omitted bus never answers the held requests
		`CHK({awready, wready, bvalid, arready, rvalid}, 5'h00)
		`CHK({bresp, rresp, rdata}, 36'h0_0000_0000)
		// a reset in mid-run clears at once, then vectors and status come back
		reset_n = 1'h0;
		@(negedge sys_clk);
		`CHK({tx_out, mac_status}, {(`MCM_TX_W + 2){1'h0}})
		reset_n = 1'h1;
		repeat (5) @(negedge sys_clk);
		`CHK({tx_out, mac_status}, {tx_cfg, 2'h2})
		// bus build: drop the held requests, then each kind of access
		awvalid = 1'h0;
		wvalid = 1'h0;
		arvalid = 1'h0;
		repeat (3) @(negedge sys_clk);
		bus_write(11'h004, 32'h1357_9BDF, `MCM_RESP_OKAY);
		bus_write(11'h048, 32'h2468_ACE0, `MCM_RESP_OKAY);
		bus_write(11'h060, 32'hFFFF_FFFF, `MCM_RESP_SLVERR);
		bus_read(11'h004, 32'h1357_9BDF, `MCM_RESP_OKAY);
		bus_read(11'h048, 32'h2468_ACE0, `MCM_RESP_OKAY);
		bus_read(11'h060, 32'h0000_0002, `MCM_RESP_OKAY);
		bus_read(11'h070, 32'h0000_0000, `MCM_RESP_SLVERR);
		`CHK(tx_out_b[63:32], 32'h1357_9BDF)
		`CHK(rx_out_b[95:64], 32'h2468_ACE0)
		results();
	end
endmodule
